// ==== rtl/fpvc_classifier.sv ====
`timescale 1ns/10ps
`include "fpvc_regs.svh"
// Summary of operation
// RL1: single normal: 1.frac times two^(bexp-127)
// RL2: double normal: 1.frac times two^(bexp-1023)
// RL3: double needs even then next odd register
// RL4: nan: exponent all ones, fraction nonzero
// RL5: fraction msb one quiet, zero signaling
// RL6: signaling nan input raises invalid operation
// RL7: nan results are default quiet nan only
// RL8: reserved-operand enable turns nan into trap
// RL9: infinity: exponent ones, fraction zero, signed
// RL10: denormal: zero exponent, nonzero fraction, accepted
// RL11: tiny results kept denormal, not flushed
// RL12: zero either sign; zeros compare equal
// RL13: fields 1/8/23 single, 1/11/52 double
module fpvc_classifier (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // control
  input wire logic i_rsvd_op_en,
  input wire logic i_op_invalid,
  // operands
  input fpvc_pkg::fpvc_operand_t i_opa,
  input fpvc_pkg::fpvc_operand_t i_opb,
  input wire logic [7:0] i_opa_reg1,
  input wire logic [7:0] i_opb_reg1,
  // candidate result from the arithmetic path
  input wire logic [63:0] i_arith_value,
  // outputs
  output fpvc_pkg::fpvc_result_t o_result,
  output fpvc_pkg::fpvc_class_t o_cls_a,
  output fpvc_pkg::fpvc_class_t o_cls_b,
  output logic signed [12:0] o_exp_a,
  output logic signed [12:0] o_exp_b
);
  import fpvc_pkg::*;

  fpvc_info_t info_a;
  fpvc_info_t info_b;
  logic mis_a;
  logic mis_b;
  logic snan_a;
  logic snan_b;
  logic qnan_a;
  logic qnan_b;
  logic nan_a;
  logic nan_b;
  logic zero_a;
  logic zero_b;
  logic any_valid;
  logic dbl;
  logic snan_in;
  logic nan_in;
  logic invalid;
  logic [63:0] sp_qnan;
  logic [63:0] dp_qnan;
  logic valid_nxt;
  logic dbl_nxt;
  logic nan_out_nxt;
  logic invalid_nxt;
  logic trap_nxt;
  logic misalign_nxt;
  logic zero_equal_nxt;
  logic [63:0] value_nxt;
  fpvc_class_t cls_a_nxt;
  fpvc_class_t cls_b_nxt;
  logic signed [12:0] exp_a_nxt;
  logic signed [12:0] exp_b_nxt;
  logic valid_r;
  logic dbl_r;
  logic nan_out_r;
  logic invalid_r;
  logic trap_r;
  logic misalign_r;
  logic zero_equal_r;
  logic [63:0] value_r;
  fpvc_class_t cls_a_r;
  fpvc_class_t cls_b_r;
  logic signed [12:0] exp_a_r;
  logic signed [12:0] exp_b_r;

  fpvc_decode u_dec_a (
    .i_dbl(i_opa.dbl),
    .i_word0(i_opa.word0),
    .i_word1(i_opa.word1),
    .o_info(info_a)
  );

  fpvc_decode u_dec_b (
    .i_dbl(i_opb.dbl),
    .i_word0(i_opb.word0),
    .i_word1(i_opb.word1),
    .o_info(info_b)
  );

  fpvc_align u_al_a (
    .i_dbl(i_opa.dbl),
    .i_reg0(i_opa.reg_a),
    .i_reg1(i_opa_reg1),
    .o_misalign(mis_a)
  );

  fpvc_align u_al_b (
    .i_dbl(i_opb.dbl),
    .i_reg0(i_opb.reg_a),
    .i_reg1(i_opb_reg1),
    .o_misalign(mis_b)
  );

  // operand a flags; an idle operand never counts
  always_comb begin
    snan_a = i_opa.valid && (info_a.cls == FPVC_CLS_SNAN); // [RL5]
    qnan_a = i_opa.valid && (info_a.cls == FPVC_CLS_QNAN); // [RL5]
    nan_a = snan_a || qnan_a; // [RL4]
    zero_a = i_opa.valid && (info_a.cls == FPVC_CLS_ZERO); // [RL12]
  end

  // operand b flags
  always_comb begin
    snan_b = i_opb.valid && (info_b.cls == FPVC_CLS_SNAN); // [RL5]
    qnan_b = i_opb.valid && (info_b.cls == FPVC_CLS_QNAN); // [RL5]
    nan_b = snan_b || qnan_b; // [RL4]
    zero_b = i_opb.valid && (info_b.cls == FPVC_CLS_ZERO); // [RL12]
  end

  // format follows operand a while a is offered, otherwise operand b
  always_comb begin
    any_valid = i_opa.valid || i_opb.valid;
    dbl = i_opa.valid ? i_opa.dbl : i_opb.dbl;
  end

  always_comb begin
    snan_in = snan_a || snan_b;
    nan_in = nan_a || nan_b;
    // quiet nan input alone is not invalid
    invalid = snan_in || i_op_invalid; // [RL6]
  end

  // sign of the default nan left clear
  always_comb begin
    sp_qnan = {32'h0, 1'b0, `FPVC_SP_EXP_ONES,
               `FPVC_SP_QNAN_FRAC}; // [RL7]
    dp_qnan = {1'b0, `FPVC_DP_EXP_ONES, `FPVC_DP_QNAN_FRAC}; // [RL7]
  end

  // valid stays low while no operand is offered; dbl still follows operand b
  always_comb begin
    valid_nxt = any_valid;
    dbl_nxt = dbl;
  end

  always_comb begin
    nan_out_nxt = any_valid && (invalid || nan_in); // [RL7]
    invalid_nxt = any_valid && invalid; // [RL6]
    trap_nxt = any_valid && nan_in && i_rsvd_op_en; // [RL8]
  end

  // placement only matters for double operands
  always_comb begin
    misalign_nxt = (i_opa.valid && mis_a) || (i_opb.valid && mis_b); // [RL3]
  end

  // sign ignored, so both zeros compare equal
  always_comb begin
    zero_equal_nxt = zero_a && zero_b; // [RL12]
  end

  // arithmetic value passes untouched so denormals are not flushed
  always_comb begin
    value_nxt = 64'h0;
    if (any_valid && (invalid || nan_in)) begin
      if (dbl) begin
        value_nxt = dp_qnan; // [RL7]
      end else begin
        value_nxt = sp_qnan; // [RL7]
      end
    end else if (any_valid) begin
      value_nxt = i_arith_value; // [RL11]
    end
  end

  // classes and exponents update every cycle, idle or not
  always_comb begin
    cls_a_nxt = info_a.cls; // [RL4] [RL9] [RL10] [RL12]
    cls_b_nxt = info_b.cls;
  end

  always_comb begin
    exp_a_nxt = info_a.unb_exp; // [RL1] [RL2] [RL10]
    exp_b_nxt = info_b.unb_exp;
  end

  // one register per field, each straight to an output
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dbl_r <= 1'b0;
    end else begin
      dbl_r <= dbl_nxt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      nan_out_r <= 1'b0;
    end else begin
      nan_out_r <= nan_out_nxt; // [RL7]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      invalid_r <= 1'b0;
    end else begin
      invalid_r <= invalid_nxt; // [RL6]
    end
  end

  // trap rides along; the quiet nan is still returned
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      trap_r <= 1'b0;
    end else begin
      trap_r <= trap_nxt; // [RL8]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      misalign_r <= 1'b0;
    end else begin
      misalign_r <= misalign_nxt; // [RL3]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      zero_equal_r <= 1'b0;
    end else begin
      zero_equal_r <= zero_equal_nxt; // [RL12]
    end
  end

  // value clears while idle, never stale
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      value_r <= 64'h0;
    end else begin
      value_r <= value_nxt; // [RL11]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cls_a_r <= FPVC_CLS_ZERO;
    end else begin
      cls_a_r <= cls_a_nxt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cls_b_r <= FPVC_CLS_ZERO;
    end else begin
      cls_b_r <= cls_b_nxt;
    end
  end

  // denormals carry one minus the bias
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      exp_a_r <= '0;
    end else begin
      exp_a_r <= exp_a_nxt; // [RL10]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      exp_b_r <= '0;
    end else begin
      exp_b_r <= exp_b_nxt;
    end
  end

  assign o_result = {valid_r, dbl_r, nan_out_r, invalid_r, trap_r,
                     misalign_r, zero_equal_r, value_r};
  assign o_cls_a = cls_a_r;
  assign o_cls_b = cls_b_r;
  assign o_exp_a = exp_a_r;
  assign o_exp_b = exp_b_r;
endmodule

// ==== shared/fpvc_regs.svh ====
`ifndef FPVC_REGS_SVH
`define FPVC_REGS_SVH

`define FPVC_SP_EXP_W 8
`define FPVC_SP_FRAC_W 23
`define FPVC_DP_EXP_W 11
`define FPVC_DP_FRAC_W 52
`define FPVC_SP_BIAS 11'h07F
`define FPVC_DP_BIAS 11'h3FF
`define FPVC_SP_SIGN_BIT 31
`define FPVC_SP_EXP_HI 30
`define FPVC_SP_EXP_LO 23
`define FPVC_SP_FRAC_HI 22
`define FPVC_DP_SIGN_BIT 63
`define FPVC_DP_EXP_HI 62
`define FPVC_DP_EXP_LO 52
`define FPVC_DP_FRAC_HI 51
`define FPVC_SP_QNAN_FRAC 23'h600000
`define FPVC_DP_QNAN_FRAC 52'hC000000000000
`define FPVC_SP_EXP_ONES 8'hFF
`define FPVC_DP_EXP_ONES 11'h7FF

`endif

// ==== shared/fpvc_pkg.sv ====
package fpvc_pkg;

  typedef enum logic [5:0] {
    FPVC_CLS_NORMAL = 6'h01,
    FPVC_CLS_DENORM = 6'h02,
    FPVC_CLS_ZERO = 6'h04,
    FPVC_CLS_INF = 6'h08,
    FPVC_CLS_SNAN = 6'h10,
    FPVC_CLS_QNAN = 6'h20
  } fpvc_class_t;

  typedef struct packed {
    logic sign;
    logic [10:0] bexp;
    logic [51:0] frac;
  } fpvc_fields_t;

  typedef struct packed {
    logic valid;
    logic dbl;
    logic [7:0] reg_a;
    logic [31:0] word0;
    logic [31:0] word1;
  } fpvc_operand_t;

  typedef struct packed {
    fpvc_class_t cls;
    fpvc_fields_t fields;
    logic signed [12:0] unb_exp;
  } fpvc_info_t;

  typedef struct packed {
    logic valid;
    logic dbl;
    logic nan_out;
    logic invalid;
    logic trap;
    logic misalign;
    logic zero_equal;
    logic [63:0] value;
  } fpvc_result_t;

endpackage

// ==== rtl/fpvc_decode.sv ====
`timescale 1ns/10ps
`include "fpvc_regs.svh"
module fpvc_decode (
  // operand
  input wire logic i_dbl,
  input wire logic [31:0] i_word0,
  input wire logic [31:0] i_word1,
  // decoded
  output fpvc_pkg::fpvc_info_t o_info
);
  import fpvc_pkg::*;

  logic all_ones;
  logic exp_zero;
  logic frac_nz;
  logic frac_msb;

  always_comb begin
    o_info = '0;
    if (i_dbl) begin
      // sign and exponent come from the first word
      o_info.fields.sign = i_word0[`FPVC_DP_SIGN_BIT - 32];
      o_info.fields.bexp = i_word0[`FPVC_DP_EXP_HI - 32:`FPVC_DP_EXP_LO - 32];
      o_info.fields.frac = {i_word0[`FPVC_DP_FRAC_HI - 32:0], i_word1}; // [RL13]
      all_ones = (o_info.fields.bexp == `FPVC_DP_EXP_ONES);
      // [RL2]
      o_info.unb_exp = $signed({2'b00, o_info.fields.bexp})
                       - $signed({2'b00, `FPVC_DP_BIAS});
      frac_msb = o_info.fields.frac[`FPVC_DP_FRAC_HI];
    end else begin
      o_info.fields.sign = i_word0[`FPVC_SP_SIGN_BIT];
      o_info.fields.bexp = {3'h0, i_word0[`FPVC_SP_EXP_HI:`FPVC_SP_EXP_LO]};
      o_info.fields.frac = {29'h0, i_word0[`FPVC_SP_FRAC_HI:0]}; // [RL13]
      all_ones = (o_info.fields.bexp[7:0] == `FPVC_SP_EXP_ONES);
      // [RL1]
      o_info.unb_exp = $signed({2'b00, o_info.fields.bexp})
                       - $signed({2'b00, `FPVC_SP_BIAS});
      frac_msb = o_info.fields.frac[`FPVC_SP_FRAC_HI];
    end
    exp_zero = (o_info.fields.bexp == 11'h000);
    frac_nz = |o_info.fields.frac;
    if (all_ones && frac_nz) begin
      // sign ignored for nan
      o_info.cls = frac_msb ? FPVC_CLS_QNAN : FPVC_CLS_SNAN; // [RL4] [RL5]
    end else if (all_ones) begin
      o_info.cls = FPVC_CLS_INF; // [RL9]
    end else if (exp_zero && frac_nz) begin
      // denormal exponent is one minus bias
      o_info.cls = FPVC_CLS_DENORM; // [RL10] [RL11]
      o_info.unb_exp = o_info.unb_exp + 13'sh0001;
    end else if (exp_zero) begin
      o_info.cls = FPVC_CLS_ZERO; // [RL12]
    end else begin
      o_info.cls = FPVC_CLS_NORMAL;
    end
  end
endmodule

// ==== rtl/fpvc_align.sv ====
`timescale 1ns/10ps
module fpvc_align (
  // register numbers
  input wire logic i_dbl,
  input wire logic [7:0] i_reg0,
  input wire logic [7:0] i_reg1,
  // flag
  output logic o_misalign
);
  import fpvc_pkg::*;

  always_comb begin
    o_misalign = 1'b0;
    if (i_dbl) begin
      // first word even, second the next odd one
      o_misalign = i_reg0[0] || (i_reg1 != (i_reg0 | 8'h01)); // [RL3]
    end
  end
endmodule

// ==== tb/fpvc_properties.sv ====
`timescale 1ns/10ps
module fpvc_properties (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // watched ports
  input wire logic i_rsvd_op_en,
  input fpvc_pkg::fpvc_operand_t i_opa,
  input fpvc_pkg::fpvc_result_t o_result,
  input fpvc_pkg::fpvc_class_t o_cls_a,
  input wire logic signed [12:0] o_exp_a
);
  import fpvc_pkg::*;
  wire logic s = !i_opa.dbl;
  wire logic [7:0] e = i_opa.word0[30:23];
  wire logic [22:0] f = i_opa.word0[22:0];
  wire logic [10:0] de = i_opa.word0[30:20];
  wire logic nan = s && e == 8'hFF && f != 23'h0;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_snan;
    i_opa.valid && nan && !f[22];
  endsequence
  AST_SNAN: assert property (s_snan |=> o_cls_a == FPVC_CLS_SNAN
    && o_result.invalid) else $error("snan not flagged");
  AST_QNAN: assert property (nan && f[22] |=> o_cls_a == FPVC_CLS_QNAN)
    else $error("qnan class wrong");
  AST_INF: assert property (s && e == 8'hFF && f == 23'h0
    |=> o_cls_a == FPVC_CLS_INF) else $error("inf class wrong");
  AST_DEN: assert property (s && e == 8'h0 && f != 23'h0
    |=> o_cls_a == FPVC_CLS_DENORM && o_exp_a == -13'sh7E)
    else $error("denormal wrong");
  AST_ZERO: assert property (s && e == 8'h0 && f == 23'h0
    |=> o_cls_a == FPVC_CLS_ZERO) else $error("zero class wrong");
  AST_NORM: assert property (s && e != 8'h0 && e != 8'hFF
    |=> o_cls_a == FPVC_CLS_NORMAL
    && o_exp_a == $signed({5'h0, $past(e)}) - 13'sh7F)
    else $error("single normal wrong");
  AST_DNORM: assert property (!s && de != 11'h0 && de != 11'h7FF
    |=> o_exp_a == $signed({2'h0, $past(de)}) - 13'sh3FF)
    else $error("double exponent wrong");
  AST_DFLT: assert property (o_result.nan_out |-> o_result.value ==
    (o_result.dbl ? 64'h7FFC000000000000 : 64'h000000007FE00000))
    else $error("nan result not default");
  AST_TRAP: assert property (i_opa.valid && nan && i_rsvd_op_en
    |=> o_result.trap) else $error("trap missing");
endmodule
bind fpvc_classifier fpvc_properties i_props (.*);

// ==== tb/fpvc_classifier_tb.sv ====
`timescale 1ns/10ps
module fpvc_classifier_tb;
  import fpvc_pkg::*;
  logic i_mclk = 1'h0;
  logic i_rst_n = 1'h0;
  logic en = 1'h0;
  logic inv = 1'h0;
  fpvc_operand_t a = '0;
  fpvc_operand_t b = '0;
  logic [7:0] a1 = 8'h0;
  logic [7:0] b1 = 8'h0;
  logic [63:0] av = 64'h0;
  logic [31:0] r;
  logic [31:0] sd = 32'h1980;
  fpvc_result_t res;
  fpvc_class_t ca;
  fpvc_class_t cb;
  logic signed [12:0] xa;
  logic signed [12:0] xb;
  int error_cnt = 0;
  int checked = 0;
  always #5 i_mclk = ~i_mclk;
  fpvc_classifier i_fpvc_classifier (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_rsvd_op_en(en), .i_op_invalid(inv), .i_opa(a), .i_opb(b),
    .i_opa_reg1(a1), .i_opb_reg1(b1), .i_arith_value(av),
    .o_result(res), .o_cls_a(ca), .o_cls_b(cb), .o_exp_a(xa), .o_exp_b(xb));
  function logic [31:0] rnd();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction
  // biased toward special exponents and empty fractions
  function automatic fpvc_operand_t rop();
    fpvc_operand_t o;
    logic [31:0] q;
    q = rnd();
    o = {q[1:0] != 2'h0, q[2], q[15:8], rnd(), rnd()};
    if (q[4:3] == 2'h0) o.word0[30:20] = 11'h7FF;
    if (q[4:3] == 2'h0) o.word0[22] = q[6];
    if (q[4:3] == 2'h1) o.word0[30:20] = 11'h0;
    if (q[5] && o.dbl) o.word0[19:0] = '0;
    if (q[5] && o.dbl) o.word1 = '0;
    if (q[5] && !o.dbl) o.word0[22:0] = '0;
    return o;
  endfunction
  // class in [18:13], unbiased exponent in [12:0]
  function automatic logic [18:0] dec(input fpvc_operand_t o);
    logic [10:0] e;
    logic [51:0] f;
    e = o.dbl ? o.word0[30:20] : {3'h0, o.word0[30:23]};
    f = o.dbl ? {o.word0[19:0], o.word1} : {o.word0[22:0], 29'h0};
    dec[12:0] = (e == 11'h0 ? 13'h1 : {2'h0, e}) - (o.dbl ? 13'h3FF : 13'h7F);
    if (e == (o.dbl ? 11'h7FF : 11'h0FF))
      dec[18:13] = f == 52'h0 ? FPVC_CLS_INF
                 : f[51] ? FPVC_CLS_QNAN : FPVC_CLS_SNAN;
    else
      dec[18:13] = e != 11'h0 ? FPVC_CLS_NORMAL
                 : f == 52'h0 ? FPVC_CLS_ZERO : FPVC_CLS_DENORM;
  endfunction
  function automatic logic mis(input fpvc_operand_t o, input logic [7:0] r1);
    return o.valid && o.dbl && (o.reg_a[0] || r1 != (o.reg_a | 8'h01));
  endfunction
  task automatic chk(input string n, input logic [127:0] e, g);
    checked++;
    if (e !== g) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic run();
    fpvc_result_t x;
    logic [18:0] da;
    logic [18:0] db;
    logic na;
    logic nb;
    da = dec(a);
    db = dec(b);
    na = a.valid && |da[18:17];
    nb = b.valid && |db[18:17];
    x = '0;
    // format bit follows the operands even when both are idle
    x.dbl = a.valid ? a.dbl : b.dbl;
    if (a.valid || b.valid) begin
      x.valid = 1'h1;
      x.nan_out = na || nb || inv;
      x.invalid = (a.valid && da[17]) || (b.valid && db[17]) || inv;
      x.trap = (na || nb) && en;
      x.misalign = mis(a, a1) || mis(b, b1);
      x.zero_equal = a.valid && b.valid && da[15] && db[15];
      x.value = !x.nan_out ? av
              : x.dbl ? 64'h7FFC000000000000 : 64'h000000007FE00000;
    end
    @(posedge i_mclk);
    #1;
    chk("result", x, res);
    chk("class_a", da[18:13], ca);
    chk("class_b", db[18:13], cb);
    if (|da[14:13]) chk("exp_a", da[12:0], $unsigned(xa));
    if (|db[14:13]) chk("exp_b", db[12:0], $unsigned(xb));
  endtask
  task conclude();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    #1;
    i_rst_n = 1'h1;
    a = '{1'h1, 1'h0, 8'h0, 32'h0, 32'h0};
    b = '{1'h1, 1'h0, 8'h0, 32'h80000000, 32'h0};
    run();
    a.valid = 1'h0;
    b.valid = 1'h0;
    run();
    repeat (500) begin
      a = rop();
      b = rop();
      b.dbl = a.dbl;
      r = rnd();
      a1 = r[0] ? a.reg_a | 8'h01 : r[15:8];
      b1 = r[1] ? b.reg_a | 8'h01 : r[23:16];
      inv = r[2] & r[3];
      en = r[4];
      av = {rnd(), rnd()};
      run();
    end
    // reset again in mid-run; result and exponents clear, both classes load FPVC_CLS_ZERO
    i_rst_n = 1'h0;
    @(posedge i_mclk);
    #1;
    chk("rst_result", 128'h0, res);
    chk("rst_class_a", FPVC_CLS_ZERO, ca);
    chk("rst_class_b", FPVC_CLS_ZERO, cb);
    chk("rst_exp_a", 128'h0, $unsigned(xa));
    chk("rst_exp_b", 128'h0, $unsigned(xb));
    i_rst_n = 1'h1;
    run();
    run();
    conclude();
  end
endmodule
